// ---- include/lts_pkg.sv ----
// Constants shared by the link time-out and start-up configuration logic.
package lts_pkg;
  localparam int unsigned CLK_HZ = 200_000_000;
  localparam int unsigned CLK_PER_MS = CLK_HZ / 1000;
  localparam int unsigned BAUD_9600 = 9600;
  localparam int unsigned BAUD_19200 = 19200;
  localparam int unsigned BAUD_38400 = 38400;
  // Bit times are least times, so they round up to whole cycles.
  localparam int unsigned BIT_CYC_9600 = (CLK_HZ + BAUD_9600 - 1) / BAUD_9600;
  localparam int unsigned BIT_CYC_19200 = (CLK_HZ + BAUD_19200 - 1) / BAUD_19200;
  localparam int unsigned BIT_CYC_38400 = (CLK_HZ + BAUD_38400 - 1) / BAUD_38400;
  localparam int unsigned GAP_BITS = 24;
  localparam int unsigned EXT_GAP_MS = 2;
  localparam int unsigned EXT_GAP_CYC = EXT_GAP_MS * CLK_PER_MS;
  localparam int unsigned BLINK_HALF_MS = 500;
  localparam int unsigned TMR_W = 24;

  // Switch element n sits at bit n-1 of an 8-bit switch bus.
  localparam int unsigned SW_BAUD_LO = 2;
  localparam int unsigned SW_BAUD_HI = 3;
  localparam int unsigned SW_PROTO = 4;
  localparam int unsigned SW_TMODE = 6;
  localparam int unsigned SW_FIXED = 7;
  localparam int unsigned SW_PROTO12_LO = 4;
  localparam logic [3:0] PROTO12_MODBUS = 4'h1;

  localparam logic [1:0] BAUD_CODE_9600 = 2'h0;
  localparam logic [1:0] BAUD_CODE_19200 = 2'h1;
  localparam logic [1:0] BAUD_CODE_38400 = 2'h2;

  localparam logic [1:0] HOLD_NONE = 2'h0;
  localparam logic [1:0] HOLD_KEEP = 2'h1;
  localparam logic [1:0] HOLD_RUN_START = 2'h2;
  localparam logic [1:0] HOLD_RESET = 2'h0;

  localparam logic [1:0] MODE_UNUSED = 2'h0;
  localparam logic [1:0] MODE_MONITOR = 2'h1;
  localparam logic [1:0] MODE_NORMAL = 2'h3;

  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_MODE = 4'h4;
  localparam logic [3:0] REG_STATUS = 4'h8;
  localparam int unsigned CTRL_HOLD_LO = 0;
  localparam int unsigned CTRL_RUN = 8;
  localparam int unsigned STAT_MODBUS_LO = 0;
  localparam int unsigned STAT_EXT = 3;
  localparam int unsigned STAT_BUSY_LO = 4;
  localparam int unsigned STAT_READY = 7;
  localparam int unsigned STAT_SW3_LO = 8;
  localparam int unsigned STAT_SW12_LO = 16;
endpackage

// ---- logic/lts_gap_timer.sv ----
// Inter-character gap timer for one serial port.
`timescale 1ns/10ps
module lts_gap_timer #(
  parameter int unsigned W = lts_pkg::TMR_W
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic enable,
  input wire logic rx_char,
  input wire logic [W-1:0] limit,
  output logic frame_end,
  output logic busy
);
  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;
  logic busy_q;
  logic busy_d;
  logic end_q;
  logic end_d;

  always_comb begin
    cnt_d = cnt_q;
    busy_d = busy_q;
    end_d = 1'b0;
    if (!enable) begin
      cnt_d = '0;
      busy_d = 1'b0;
    end else if (rx_char) begin
      cnt_d = '0;
      busy_d = 1'b1;
    end else if (busy_q) begin
      if (cnt_q + W'(1) >= limit) begin
        end_d = 1'b1;
        busy_d = 1'b0;
        cnt_d = '0;
      end else begin
        cnt_d = cnt_q + W'(1);
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
      busy_q <= 1'b0;
      end_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      busy_q <= busy_d;
      end_q <= end_d;
    end
  end

  assign frame_end = end_q;
  assign busy = busy_q;
endmodule

// ---- logic/lts_top.sv ----
// Serial time-out selection, run/stop restore and run indicator logic.
//
// The implementer's own choices: strobed register access and the placing of the registers.
`timescale 1ns/10ps
module lts_top #(
  parameter int unsigned N_CH = 8,
  parameter int unsigned BIT_CYC_9600 = lts_pkg::BIT_CYC_9600,
  parameter int unsigned BIT_CYC_19200 = lts_pkg::BIT_CYC_19200,
  parameter int unsigned BIT_CYC_38400 = lts_pkg::BIT_CYC_38400,
  parameter int unsigned EXT_GAP_CYC = lts_pkg::EXT_GAP_CYC,
  parameter int unsigned MS_CYC = lts_pkg::CLK_PER_MS,
  parameter int unsigned BLINK_HALF_MS = lts_pkg::BLINK_HALF_MS
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [7:0] port3_config_switch,
  input wire logic [7:0] port12_config_switch,
  input wire logic [2:0] rx_char,
  output logic [2:0] frame_end,
  output logic [2:0] port_modbus,
  input wire logic [1:0] saved_hold,
  input wire logic saved_run,
  input wire logic [2*N_CH-1:0] saved_mode,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic [1:0] run_stop_hold_setting,
  output logic control_run,
  output logic [2*N_CH-1:0] op_mode,
  output logic [N_CH-1:0] control_active,
  output logic run_led,
  output logic startup_done
);
  localparam int unsigned W = lts_pkg::TMR_W;

  typedef enum logic [1:0] {
    LTS_ST_RESTORE,
    LTS_ST_ACTIVE
  } lts_state_e;

  // Switch pins are asynchronous to the clock, so each bit is synchronised.
  logic [15:0] sw_meta_q;
  logic [15:0] sw_sync_q;
  logic [7:0] sw3;
  logic [7:0] sw12;
  logic ext_mode;
  logic [2:0] modbus;
  logic [W-1:0] lim12;
  logic [W-1:0] lim3;
  logic [2:0] busy;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sw_meta_q <= 16'h0000;
      sw_sync_q <= 16'h0000;
    end else begin
      sw_meta_q <= {port12_config_switch, port3_config_switch};
      sw_sync_q <= sw_meta_q;
    end
  end

  assign sw3 = sw_sync_q[7:0];
  assign sw12 = sw_sync_q[15:8];
  assign ext_mode = sw3[lts_pkg::SW_TMODE];
  // A switch moved mid-frame changes the limit at once, so switches are expected to move
  // only while the line is idle.

  // Element 8 of the port three switch is left alone by the configurer, so it is read only into the status word.

  function automatic logic [W-1:0] gap_limit(input logic [1:0] baud, input logic ext);
    logic [W-1:0] bit_cyc;
    logic [W-1:0] lim;
    case (baud)
      lts_pkg::BAUD_CODE_19200: bit_cyc = W'(BIT_CYC_19200);
      lts_pkg::BAUD_CODE_38400: bit_cyc = W'(BIT_CYC_38400);
      // The forbidden speed code falls back to the slowest rate, the safest gap.
      default: bit_cyc = W'(BIT_CYC_9600);
    endcase
    // The slowest rate with the extension still fits the timer width with room to spare.
    lim = W'(bit_cyc * W'(lts_pkg::GAP_BITS));
    if (ext) begin
      lim = lim + W'(EXT_GAP_CYC);
    end
    return lim;
  endfunction

  // Ports one and two share a switch, so they share a protocol and a speed.
  assign modbus[0] = (sw12[lts_pkg::SW_PROTO12_LO +: 4] == lts_pkg::PROTO12_MODBUS);
  assign modbus[1] = modbus[0];
  assign modbus[2] = sw3[lts_pkg::SW_PROTO];
  assign lim12 = gap_limit(sw12[lts_pkg::SW_BAUD_HI:lts_pkg::SW_BAUD_LO], ext_mode);
  assign lim3 = gap_limit(sw3[lts_pkg::SW_BAUD_HI:lts_pkg::SW_BAUD_LO], ext_mode);

  // Every port has a timer of its own, since a master may talk on all three at once.
  for (genvar p = 0; p < 3; p++) begin : g_port
    lts_gap_timer #(
      .W(W)
    ) i_lts_gap_timer (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .enable(modbus[p]),
      .rx_char(rx_char[p]),
      .limit((p == 2) ? lim3 : lim12),
      .frame_end(frame_end[p]),
      .busy(busy[p])
    );
  end

  assign port_modbus = modbus;

  // Start-up restore and the run/stop, mode and hold registers.
  lts_state_e state_q;
  lts_state_e state_d;
  logic [1:0] hold_q;
  logic [1:0] hold_d;
  logic run_q;
  logic run_d;
  logic [2*N_CH-1:0] mode_q;
  logic [2*N_CH-1:0] mode_d;
  logic [N_CH-1:0] act_q;
  logic [N_CH-1:0] act_d;

  // Each channel owns two adjacent bits of a mode vector, channel zero lowest.
  function automatic logic [1:0] chan_mode(
    input logic [2*N_CH-1:0] modes,
    input int c
  );
    return modes[2*c +: 2];
  endfunction

  // A register write counts only when the strobe meets the matching offset.
  function automatic logic wr_hit(
    input logic wr,
    input logic [3:0] addr,
    input logic [3:0] target
  );
    return wr && (addr == target);
  endfunction

  // The ready flag and the start-up output share one state decode.
  function automatic logic is_active(input lts_state_e st);
    return st == LTS_ST_ACTIVE;
  endfunction

  always_comb begin
    state_d = state_q;
    hold_d = hold_q;
    run_d = run_q;
    mode_d = mode_q;
    case (state_q)
      LTS_ST_RESTORE: begin
        // The backup memory is read only after reset release, never under reset.
        // The hold setting is kept as stored, an undefined value included, so software can
        // see what the backup memory held.
        hold_d = saved_hold;
        mode_d = saved_mode;
        state_d = LTS_ST_ACTIVE;
        case (saved_hold)
          lts_pkg::HOLD_NONE: begin
            run_d = 1'b0;
          end
          lts_pkg::HOLD_KEEP: run_d = saved_run;
          lts_pkg::HOLD_RUN_START: begin
            run_d = 1'b1;
            for (int c = 0; c < N_CH; c++) begin
              if (chan_mode(saved_mode, c) != lts_pkg::MODE_UNUSED) begin
                mode_d[2*c +: 2] = lts_pkg::MODE_MONITOR;
              end
            end
          end
          // An undefined hold value is treated like the no-hold case.
          default: run_d = 1'b0;
        endcase
      end
      LTS_ST_ACTIVE: begin
        // Writes are refused in the restore cycle so that the backup values land untouched.
        if (wr_hit(reg_wr, reg_addr, lts_pkg::REG_CTRL)) begin
          hold_d = reg_wdata[lts_pkg::CTRL_HOLD_LO +: 2];
          run_d = reg_wdata[lts_pkg::CTRL_RUN];
        end
        if (wr_hit(reg_wr, reg_addr, lts_pkg::REG_MODE)) begin
          mode_d = reg_wdata[2*N_CH-1:0];
        end
      end
      default: state_d = LTS_ST_RESTORE;
    endcase
    // Monitor channels stay passive even in run, since only normal mode drives an output.
    for (int c = 0; c < N_CH; c++) begin
      act_d[c] = run_d && (chan_mode(mode_d, c) == lts_pkg::MODE_NORMAL);
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= LTS_ST_RESTORE;
      hold_q <= lts_pkg::HOLD_RESET;
      run_q <= 1'b0;
      mode_q <= '0;
      act_q <= '0;
    end else begin
      state_q <= state_d;
      hold_q <= hold_d;
      run_q <= run_d;
      mode_q <= mode_d;
      act_q <= act_d;
    end
  end

  assign run_stop_hold_setting = hold_q;
  assign control_run = run_q;
  assign op_mode = mode_q;
  assign control_active = act_q;
  assign startup_done = is_active(state_q);

  // Run indicator: a millisecond enable divides down to the blink half period.
  // It starts dark and blinks from reset release: it shows that clock and reset are alive,
  // not that a master is talking.
  logic [W-1:0] ms_cnt_q;
  logic [W-1:0] ms_cnt_d;
  logic [15:0] blink_cnt_q;
  logic [15:0] blink_cnt_d;
  logic led_q;
  logic led_d;
  logic ms_tick;

  always_comb begin
    ms_tick = (ms_cnt_q == W'(MS_CYC - 1));
    ms_cnt_d = ms_tick ? '0 : ms_cnt_q + W'(1);
    blink_cnt_d = blink_cnt_q;
    led_d = led_q;
    if (ms_tick) begin
      if (blink_cnt_q == 16'(BLINK_HALF_MS - 1)) begin
        blink_cnt_d = 16'h0000;
        led_d = ~led_q;
      end else begin
        blink_cnt_d = blink_cnt_q + 16'h0001;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ms_cnt_q <= '0;
      blink_cnt_q <= 16'h0000;
      led_q <= 1'b0;
    end else begin
      ms_cnt_q <= ms_cnt_d;
      blink_cnt_q <= blink_cnt_d;
      led_q <= led_d;
    end
  end

  assign run_led = led_q;

  // Register read port: data stands in the cycle after the strobe, zero otherwise.
  // Reads have no side effects, so a master may poll the status word as often as it likes.
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;

  always_comb begin
    rdata_d = 32'h0000_0000;
    if (reg_rd) begin
      case (reg_addr)
        lts_pkg::REG_CTRL: begin
          rdata_d[lts_pkg::CTRL_HOLD_LO +: 2] = hold_q;
          rdata_d[lts_pkg::CTRL_RUN] = run_q;
        end
        lts_pkg::REG_MODE: rdata_d[2*N_CH-1:0] = mode_q;
        lts_pkg::REG_STATUS: begin
          rdata_d[lts_pkg::STAT_MODBUS_LO +: 3] = modbus;
          rdata_d[lts_pkg::STAT_EXT] = ext_mode;
          rdata_d[lts_pkg::STAT_BUSY_LO +: 3] = busy;
          rdata_d[lts_pkg::STAT_READY] = is_active(state_q);
          rdata_d[lts_pkg::STAT_SW3_LO +: 8] = sw3;
          rdata_d[lts_pkg::STAT_SW12_LO +: 8] = sw12;
        end
        default: rdata_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= 32'h0000_0000;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;
endmodule

// ---- testbench/lts_host_model.sv ----
// Bus master model that sends characters to the three serial ports.
`timescale 1ns/10ps
module lts_host_model (
  input wire logic sys_clk,
  output logic [2:0] rx_char
);
  initial rx_char = 3'h0;
  // A slow master spaces characters widely; any gap under the limit keeps one frame.
  // Unit addresses and the fixed switch element are the configurer's job, not traffic.
  task automatic burst(input int p, input int n, input int gap);
    for (int i = 0; i < n; i++) begin
      if (i > 0) repeat (gap - 1) @(posedge sys_clk);
      @(posedge sys_clk);
      rx_char[p] <= 1'b1;
      @(posedge sys_clk);
      rx_char[p] <= 1'b0;
    end
  endtask
endmodule

// ---- testbench/lts_top_assertions.sv ----
// Checker for gap framing, power-up restore and run indicator of lts_top.
`timescale 1ns/10ps
module lts_top_assertions #(
  parameter int unsigned N_CH = 8,
  parameter int unsigned BIT_CYC_9600 = 1,
  parameter int unsigned BIT_CYC_19200 = 1,
  parameter int unsigned BIT_CYC_38400 = 1,
  parameter int unsigned EXT_GAP_CYC = 1,
  parameter int unsigned MS_CYC = 1,
  parameter int unsigned BLINK_HALF_MS = 1
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [7:0] port3_config_switch,
  input wire logic [7:0] port12_config_switch,
  input wire logic [2:0] rx_char,
  input wire logic [2:0] frame_end,
  input wire logic [2:0] port_modbus,
  input wire logic [1:0] saved_hold,
  input wire logic saved_run,
  input wire logic [2*N_CH-1:0] saved_mode,
  input wire logic control_run,
  input wire logic [2*N_CH-1:0] op_mode,
  input wire logic [N_CH-1:0] control_active,
  input wire logic run_led,
  input wire logic startup_done
);
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);
  localparam int unsigned HALF = BLINK_HALF_MS * MS_CYC;
  logic [15:0] gap_q [3];
  logic armed_q [3];
  logic [15:0] led_q;
  logic [2*N_CH-1:0] mon_mode;
  logic [N_CH-1:0] act_exp;
  function automatic int unsigned gap_len(input logic [1:0] sp, input logic ext);
    int unsigned bc;
    bc = sp == 2'h1 ? BIT_CYC_19200 : sp == 2'h2 ? BIT_CYC_38400 : BIT_CYC_9600;
    return 24 * bc + (ext ? EXT_GAP_CYC : 0);
  endfunction
  always_comb begin
    for (int c = 0; c < N_CH; c++) begin
      mon_mode[2*c+:2] = saved_mode[2*c+:2] != 2'h0 ? 2'h1 : 2'h0;
      act_exp[c] = control_run && op_mode[2*c+:2] == 2'h3;
    end
  end
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      led_q <= '0;
    end else begin
      led_q <= $changed(run_led) ? '0 : led_q + 16'h1;
    end
  end
  for (genvar p = 0; p < 3; p++) begin : g_port
    int unsigned lim;
    // Raw switches are used; the bench only moves them while every port is idle.
    assign lim = gap_len(p == 2 ? port3_config_switch[3:2] : port12_config_switch[3:2],
      port3_config_switch[6]);
    always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
        gap_q[p] <= '0;
        armed_q[p] <= 1'b0;
      end else begin
        gap_q[p] <= rx_char[p] ? '0 : gap_q[p] + 16'h1;
        armed_q[p] <= port_modbus[p] && (rx_char[p] || (armed_q[p] && !frame_end[p]));
      end
    end
    chk_gap_early: assert property (frame_end[p] |-> armed_q[p] && gap_q[p] == lim)
      else $error("frame ended before the gap limit");
    chk_gap_late: assert property (armed_q[p] |-> gap_q[p] <= lim)
      else $error("frame end missing after the gap limit");
    chk_port_quiet: assert property (!port_modbus[p] |-> !frame_end[p])
      else $error("frame end on a port without gap framing");
  end
  chk_proto_sel: assert property ($past(port3_config_switch, 2) == $past(port3_config_switch)
    && $past(port12_config_switch, 2) == $past(port12_config_switch) && $past(startup_done, 2)
    |-> port_modbus == {$past(port3_config_switch[4], 2),
    {2{$past(port12_config_switch[7:4], 2) == 4'h1}}}) else $error("protocol select wrong");
  chk_hold_stop: assert property ($rose(startup_done) && saved_hold[0] == saved_hold[1] |->
    !control_run && op_mode == saved_mode) else $error("hold 0 restore wrong");
  chk_hold_keep: assert property ($rose(startup_done) && saved_hold == 2'h1 |->
    control_run == saved_run && op_mode == saved_mode) else $error("hold 1 restore wrong");
  chk_hold_start: assert property ($rose(startup_done) && saved_hold == 2'h2 |->
    control_run && op_mode == mon_mode) else $error("hold 2 restore wrong");
  chk_ctrl_active: assert property (startup_done |-> control_active == act_exp)
    else $error("control active wrong");
  chk_led_hold: assert property (led_q <= HALF)
    else $error("run indicator stuck");
  chk_led_toggle: assert property ($changed(run_led) |-> led_q + 2 >= HALF)
    else $error("run indicator toggled early");
endmodule

// ---- testbench/test_lts_top.sv ----
// Self-checking bench for the link time-out and start-up logic.
`timescale 1ns/10ps
module test_lts_top;
  localparam int unsigned B96 = 10, B192 = 5, B384 = 3, EXT = 20;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] port3_config_switch = 8'h10;
  logic [7:0] port12_config_switch = 8'h10;
  logic [1:0] saved_hold = 2'h0;
  logic saved_run = 1'b1;
  logic [15:0] saved_mode = 16'h1BE4;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [2:0] rx_char, frame_end, port_modbus;
  logic [31:0] reg_rdata;
  logic [1:0] run_stop_hold_setting;
  logic control_run, run_led, startup_done;
  logic [15:0] op_mode;
  logic [7:0] control_active;
  int n_fail = 0;
  int num_checks = 0;
  int cycles = 0;
  logic [15:0] e_mode [4] = '{16'h1BE4, 16'h1BE4, 16'h1554, 16'h1BE4};
  logic [7:0] e_act [4] = '{8'h00, 8'h18, 8'h00, 8'h00};
  logic [7:0] f_s3 [7] = '{8'h10, 8'h50, 8'h58, 8'h18, 8'h40, 8'h10, 8'h1C};
  logic [7:0] f_s12 [7] = '{8'h10, 8'h14, 8'h10, 8'h10, 8'h10, 8'h30, 8'h10};
  int f_p [7] = '{0, 1, 2, 2, 2, 0, 2};
  int f_l [7] = '{24*B96, 24*B192+EXT, 24*B384+EXT, 24*B384, 0, 0, 24*B96};
  lts_top #(.BIT_CYC_9600(B96), .BIT_CYC_19200(B192), .BIT_CYC_38400(B384),
    .EXT_GAP_CYC(EXT), .MS_CYC(10), .BLINK_HALF_MS(2)) i_lts_top (.sys_clk, .rst_n,
    .port3_config_switch, .port12_config_switch, .rx_char, .frame_end, .port_modbus,
    .saved_hold, .saved_run, .saved_mode, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .run_stop_hold_setting, .control_run, .op_mode, .control_active, .run_led,
    .startup_done);
  lts_host_model i_lts_host_model (.sys_clk, .rx_char);
  initial begin
    forever #2.5 sys_clk = ~sys_clk;
  end
  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      complete_run();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    @(negedge sys_clk);
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(negedge sys_clk);
    d = reg_rdata;
  endtask
  task automatic boot(input logic [1:0] h);
    @(posedge sys_clk);
    rst_n <= 1'b0;
    saved_hold <= h;
    repeat (16) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask
  initial begin
    logic [31:0] d;
    int n;
    for (int h = 0; h < 4; h++) begin
      boot(h[1:0]);
      chk(op_mode, e_mode[h]);
      chk(run_stop_hold_setting, h);
      chk(control_run, h == 1 || h == 2);
      chk(control_active, e_act[h]);
    end
    wr(lts_pkg::REG_CTRL, 32'h100);
    chk(control_run, 32'h1);
    chk(control_active, 32'h18);
    chk(run_stop_hold_setting, 32'h0);
    rd(lts_pkg::REG_CTRL, d);
    chk(d, 32'h100);
    boot(2'h2);
    wr(lts_pkg::REG_MODE, 32'h1557);
    chk(control_active, 32'h1);
    rd(lts_pkg::REG_MODE, d);
    chk(d, 32'h1557);
    wr(4'hC, 32'hFFFF_FFFF);
    wr(lts_pkg::REG_STATUS, 32'hFFFF_FFFF);
    chk(control_active, 32'h1);
    rd(4'hC, d);
    chk(d, 32'h0);
    rd(lts_pkg::REG_STATUS, d);
    chk(d, 32'h0010_1087);
    for (int i = 0; i < 7; i++) begin
      @(posedge sys_clk);
      port3_config_switch <= f_s3[i];
      port12_config_switch <= f_s12[i];
      repeat (4) @(posedge sys_clk);
      i_lts_host_model.burst(f_p[i], 3, f_l[i] > 0 ? f_l[i] - 4 : 50);
      n = 0;
      while (frame_end[f_p[i]] !== 1'b1 && n < 300) begin
        @(negedge sys_clk);
        n++;
      end
      chk(port_modbus[f_p[i]], f_l[i] > 0);
      if (f_l[i] > 0) chk(n >= f_l[i] && n <= f_l[i] + 1, 32'h1);
      else chk(frame_end[f_p[i]], 32'h0);
    end
    complete_run();
  end
endmodule
bind lts_top lts_top_assertions #(.N_CH(N_CH), .BIT_CYC_9600(BIT_CYC_9600),
  .BIT_CYC_19200(BIT_CYC_19200), .BIT_CYC_38400(BIT_CYC_38400), .EXT_GAP_CYC(EXT_GAP_CYC),
  .MS_CYC(MS_CYC), .BLINK_HALF_MS(BLINK_HALF_MS)) i_lts_top_assertions (.sys_clk, .rst_n,
  .port3_config_switch, .port12_config_switch, .rx_char, .frame_end, .port_modbus,
  .saved_hold, .saved_run, .saved_mode, .control_run, .op_mode, .control_active, .run_led,
  .startup_done);
